/* File: core/osdma_top.sv */
`timescale 1ns/1ps
module osdma_top
#(
  parameter int CLEAR_CYCLES = osdma_pkg::OSDMA_CLEAR_CYC
)
(
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Decoded register port transaction
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_code_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic cs_rise_i,
  // Video timing and modes
  input wire logic vsync_i,
  input wire logic ext_sync_i,
  input wire logic bg_mode_i,
  input wire logic local_background_select_i,
  // Register read data
  output logic [7:0] reg_rdata_o,
  // Display memory write port
  output logic mem_we_o,
  output logic [osdma_pkg::OSDMA_ADDR_W-1:0] mem_addr_o,
  output logic [7:0] mem_char_o,
  output logic [7:0] mem_attr_o,
  output logic mem_char_we_o,
  output logic mem_attr_we_o,
  // Status and pixel source
  output logic clear_busy_o,
  output logic bg_video_o
);
  import osdma_pkg::*;

  // ------------------------------------------------------------
  // Reset synchroniser and clear timer
  // ------------------------------------------------------------
  logic rst_n;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;

  osdma_sync u_sync
  (
    .clk_i(clk_sys_i),
    .resetn_i(resetn_i),
    .resetn_o(rst_n)
  );

  osdma_clear_timer #(.CYCLES(CLEAR_CYCLES)) u_timer
  (
    .clk_i(clk_sys_i),
    .rst_ni(rst_n),
    .en_i(ce_i),
    .start_i(tmr_start),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [7:0] ah_q;
  logic [7:0] ah_d;
  logic [7:0] al_q;
  logic [7:0] al_d;
  logic [OSDMA_ADDR_W-1:0] wptr_q;
  logic [OSDMA_ADDR_W-1:0] wptr_d;
  logic auto_live_q;
  logic auto_live_d;
  logic srst_pend_q;
  logic srst_pend_d;
  logic boot_q;
  logic boot_d;
  logic [OSDMA_ADDR_W-1:0] clr_ptr_q;
  logic [OSDMA_ADDR_W-1:0] clr_ptr_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic we_q;
  logic we_d;
  logic cwe_q;
  logic cwe_d;
  logic awe_q;
  logic awe_d;
  logic [OSDMA_ADDR_W-1:0] maddr_q;
  logic [OSDMA_ADDR_W-1:0] maddr_d;
  logic [7:0] mchar_q;
  logic [7:0] mchar_d;
  logic [7:0] mattr_q;
  logic [7:0] mattr_d;
  logic bgv_q;
  logic bgv_d;
  logic busy_q;
  logic busy_d;

  logic clear_req;
  logic clear_go;
  logic wr_ctl;
  logic wr_din;
  logic mode8;
  logic [OSDMA_ADDR_W-1:0] reg_addr;
  logic [OSDMA_ADDR_W-1:0] last_addr;
  logic [7:0] attr16;

  assign clear_req = ctl_q[OSDMA_CTL_CLEAR];
  assign mode8 = ctl_q[OSDMA_CTL_MODE8];
  assign reg_addr = {ah_q[OSDMA_AH_MSB], al_q};
  assign last_addr = OSDMA_ADDR_W'(OSDMA_DEPTH - 1);
  assign attr16 = {ctl_q[OSDMA_CTL_ATTR_HI:OSDMA_CTL_ATTR_LO], 5'h00};
  assign wr_ctl = reg_wr_i && reg_code_i == OSDMA_REG_CTL;
  assign wr_din = reg_wr_i && reg_code_i == OSDMA_REG_DIN && !clear_req;
  // Immediate, or wait for vsync when the defer bit is set
  assign clear_go = clear_req && !tmr_busy && !tmr_done &&
    (!ctl_q[OSDMA_CTL_VSCLR] || vsync_i);
  assign tmr_start = clear_go;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    ctl_d = ctl_q;
    ah_d = ah_q;
    al_d = al_q;
    wptr_d = wptr_q;
    auto_live_d = auto_live_q;
    srst_pend_d = srst_pend_q;
    boot_d = 1'b0;
    clr_ptr_d = clr_ptr_q;
    rdata_d = rdata_q;
    we_d = 1'b0;
    cwe_d = 1'b0;
    awe_d = 1'b0;
    maddr_d = maddr_q;
    mchar_d = mchar_q;
    mattr_d = mattr_q;
    busy_d = tmr_busy || clear_req || boot_q;
    // Background pixel source
    bgv_d = ext_sync_i && !bg_mode_i && !local_background_select_i;
    if (tmr_done)
    begin
      ctl_d[OSDMA_CTL_CLEAR] = 1'b0;
    end

    if (wr_ctl)
    begin
      ctl_d = reg_wdata_i;
      // A running clear cannot be cancelled by software
      if (clear_req && !tmr_done)
      begin
        ctl_d[OSDMA_CTL_CLEAR] = 1'b1;
      end
      if (reg_wdata_i[OSDMA_CTL_AUTO] && !ctl_q[OSDMA_CTL_AUTO])
      begin
        auto_live_d = 1'b0;
      end
    end
    // Address registers are locked while clearing
    if (reg_wr_i && reg_code_i == OSDMA_REG_AH && !clear_req)
    begin
      ah_d = reg_wdata_i;
    end
    if (reg_wr_i && reg_code_i == OSDMA_REG_AL && !clear_req)
    begin
      al_d = reg_wdata_i;
    end
    if (reg_wr_i && reg_code_i == OSDMA_REG_VMODE0 &&
      reg_wdata_i[OSDMA_VMODE0_SRST])
    begin
      srst_pend_d = 1'b1;
    end

    // Data writes to display memory
    if (wr_din)
    begin
      if (ctl_q[OSDMA_CTL_AUTO])
      begin
        if (reg_wdata_i == OSDMA_ESCAPE)
        begin
          ctl_d[OSDMA_CTL_AUTO] = 1'b0;
          auto_live_d = 1'b0;
        end
        else
        begin
          we_d = 1'b1;
          // First write takes the programmed address
          maddr_d = auto_live_q ? wptr_q : reg_addr;
          wptr_d = (auto_live_q ? wptr_q : reg_addr) +
            OSDMA_ADDR_W'(1);
          auto_live_d = 1'b1;
        end
      end
      else
      begin
        we_d = 1'b1;
        maddr_d = reg_addr;
      end
      if (mode8)
      begin
        cwe_d = we_d && !ah_q[OSDMA_AH_BSEL];
        awe_d = we_d && ah_q[OSDMA_AH_BSEL];
        mchar_d = reg_wdata_i;
        mattr_d = reg_wdata_i;
      end
      else
      begin
        cwe_d = we_d;
        awe_d = we_d;
        mchar_d = reg_wdata_i;
        mattr_d = attr16;
      end
    end

    // Clear triggers
    if (boot_q || (cs_rise_i && srst_pend_q))
    begin
      ctl_d[OSDMA_CTL_CLEAR] = 1'b1;
      ctl_d[OSDMA_CTL_VSCLR] = 1'b0;
      srst_pend_d = 1'b0;
    end
    if (cs_rise_i)
    begin
      srst_pend_d = 1'b0;
    end
    if (ctl_d[OSDMA_CTL_CLEAR])
    begin
      ctl_d[OSDMA_CTL_AUTO] = 1'b0;
      auto_live_d = 1'b0;
    end

    // Sweep zeros through every location
    if (clear_go)
    begin
      clr_ptr_d = '0;
    end
    else if (tmr_busy)
    begin
      if (clr_ptr_q <= last_addr)
      begin
        we_d = 1'b1;
        cwe_d = 1'b1;
        awe_d = 1'b1;
        maddr_d = clr_ptr_q;
        mchar_d = OSDMA_ZERO8;
        mattr_d = OSDMA_ZERO8;
        clr_ptr_d = clr_ptr_q + OSDMA_ADDR_W'(1);
      end
    end

    if (reg_rd_i)
    begin
      case (reg_code_i)
        OSDMA_REG_CTL | OSDMA_READ_FLAG: rdata_d = ctl_q;
        OSDMA_REG_AH | OSDMA_READ_FLAG: rdata_d = ah_q;
        OSDMA_REG_AL | OSDMA_READ_FLAG: rdata_d = al_q;
        default: rdata_d = OSDMA_ZERO8;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_q <= OSDMA_ZERO8;
      ah_q <= OSDMA_ZERO8;
      al_q <= OSDMA_ZERO8;
      wptr_q <= '0;
      auto_live_q <= 1'b0;
      srst_pend_q <= 1'b0;
      boot_q <= 1'b1;
      clr_ptr_q <= '0;
      rdata_q <= OSDMA_ZERO8;
      we_q <= 1'b0;
      cwe_q <= 1'b0;
      awe_q <= 1'b0;
      maddr_q <= '0;
      mchar_q <= OSDMA_ZERO8;
      mattr_q <= OSDMA_ZERO8;
      bgv_q <= 1'b0;
      busy_q <= 1'b1;
    end
    else if (ce_i)
    begin
      ctl_q <= ctl_d;
      ah_q <= ah_d;
      al_q <= al_d;
      wptr_q <= wptr_d;
      auto_live_q <= auto_live_d;
      srst_pend_q <= srst_pend_d;
      boot_q <= boot_d;
      clr_ptr_q <= clr_ptr_d;
      rdata_q <= rdata_d;
      we_q <= we_d;
      cwe_q <= cwe_d;
      awe_q <= awe_d;
      maddr_q <= maddr_d;
      mchar_q <= mchar_d;
      mattr_q <= mattr_d;
      bgv_q <= bgv_d;
      busy_q <= busy_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign mem_we_o = we_q;
  assign mem_addr_o = maddr_q;
  assign mem_char_o = mchar_q;
  assign mem_attr_o = mattr_q;
  assign mem_char_we_o = cwe_q;
  assign mem_attr_we_o = awe_q;
  assign clear_busy_o = busy_q;
  assign bg_video_o = bgv_q;
endmodule

/* File: core/osdma_pkg.sv */
package osdma_pkg;
  // Register codes on the serial port (write code, read code = write | 0x80)
  localparam logic [7:0] OSDMA_REG_CTL = 8'h00;
  localparam logic [7:0] OSDMA_REG_VMODE0 = 8'h01;
  localparam logic [7:0] OSDMA_REG_AH = 8'h05;
  localparam logic [7:0] OSDMA_REG_AL = 8'h06;
  localparam logic [7:0] OSDMA_REG_DIN = 8'h07;
  localparam logic [7:0] OSDMA_READ_FLAG = 8'h80;
  localparam logic [7:0] OSDMA_ESCAPE = 8'hFF;
  localparam logic [7:0] OSDMA_ZERO8 = 8'h00;
  // Field positions
  localparam int OSDMA_CTL_AUTO = 0;
  localparam int OSDMA_CTL_VSCLR = 1;
  localparam int OSDMA_CTL_CLEAR = 2;
  localparam int OSDMA_CTL_ATTR_LO = 3;
  localparam int OSDMA_CTL_ATTR_HI = 5;
  localparam int OSDMA_CTL_MODE8 = 6;
  localparam int OSDMA_AH_MSB = 0;
  localparam int OSDMA_AH_BSEL = 1;
  localparam int OSDMA_VMODE0_SRST = 1;
  localparam int OSDMA_ATTR_SHIFT = 5;
  // Display memory geometry
  localparam int OSDMA_ADDR_W = 9;
  localparam int OSDMA_DEPTH = 480;
  // Clear timing
  localparam int OSDMA_CLK_MHZ = 40;
  localparam int OSDMA_CLEAR_US = 20;
  localparam int OSDMA_CLEAR_CYC = OSDMA_CLEAR_US * OSDMA_CLK_MHZ;
endpackage

/* File: core/osdma_sync.sv */
`timescale 1ns/1ps
module osdma_sync
(
  // Clock and asynchronous reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Synchronised reset
  output logic resetn_o
);
  logic s1_q;
  logic s2_q;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end
    else
    begin
      s1_q <= 1'b1;
      s2_q <= s1_q;
    end
  end
  assign resetn_o = s2_q;
endmodule

/* File: core/osdma_clear_timer.sv */
`timescale 1ns/1ps
module osdma_clear_timer
#(
  parameter int CYCLES = osdma_pkg::OSDMA_CLEAR_CYC
)
(
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic en_i,
  // Control
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  import osdma_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CMAX = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;
  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start_i && !busy_q)
    begin
      busy_d = 1'b1;
      cnt_d = '0;
    end
    else if (busy_q)
    begin
      if (cnt_q == CMAX)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (en_i)
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end
  assign busy_o = busy_q;
  assign done_o = done_q;
endmodule

/* File: verification/osdma_top_props.sv */
`timescale 1ns/1ps
module osdma_top_props
#(
  parameter int CLEAR_CYCLES = osdma_pkg::OSDMA_CLEAR_CYC
)
(
  // Clock, reset and register port
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_code_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic cs_rise_i,
  // Video and outputs
  input wire logic vsync_i,
  input wire logic ext_sync_i,
  input wire logic bg_mode_i,
  input wire logic local_background_select_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic mem_we_o,
  input wire logic [7:0] mem_char_o,
  input wire logic [7:0] mem_attr_o,
  input wire logic clear_busy_o,
  input wire logic bg_video_o
);
  import osdma_pkg::*;
  logic wr, vid, armed_d, armed_q, din_d, din_q;
  logic [15:0] cnt_d, cnt_q;
  assign wr = reg_wr_i && ce_i;
  assign vid = ext_sync_i && !bg_mode_i && !local_background_select_i;
  always_comb
  begin
    armed_d = armed_q;
    din_d = wr && reg_code_i == OSDMA_REG_DIN;
    cnt_d = clear_busy_o ? cnt_q + 16'h0001 : 16'h0000;
    if (wr && reg_code_i == OSDMA_REG_VMODE0)
      armed_d = reg_wdata_i[OSDMA_VMODE0_SRST];
    else if (cs_rise_i && ce_i)
      armed_d = 1'b0;
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      armed_q <= 1'b0;
      din_q <= 1'b0;
      cnt_q <= 16'h0000;
    end
    else
    begin
      armed_q <= armed_d;
      din_q <= din_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_clear_starts: assert property (
    wr && reg_code_i == OSDMA_REG_CTL && reg_wdata_i[OSDMA_CTL_CLEAR]
    |-> ##2 clear_busy_o) else $error("clear request left busy low");
  a_softrst_clear: assert property (
    armed_q && cs_rise_i && ce_i |-> ##2 clear_busy_o)
    else $error("soft reset did not start a clear");
  a_vsync_defer: assert property (
    (wr && reg_code_i == OSDMA_REG_CTL && !clear_busy_o
    && reg_wdata_i[OSDMA_CTL_CLEAR] && reg_wdata_i[OSDMA_CTL_VSCLR])
    ##1 !vsync_i [*3] |-> !mem_we_o)
    else $error("deferred clear wrote before vsync");
  a_sweep_zero: assert property (
    mem_we_o && clear_busy_o |-> mem_char_o == OSDMA_ZERO8
    && mem_attr_o == OSDMA_ZERO8) else $error("clear wrote nonzero");
  a_clear_length: assert property (
    $fell(clear_busy_o) |-> cnt_q >= 16'(CLEAR_CYCLES))
    else $error("clear ended too early");
  a_write_cause: assert property (
    mem_we_o && !clear_busy_o |-> din_q)
    else $error("memory write without data write");
  a_rdata_hold: assert property (
    !(reg_rd_i && ce_i) |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  a_bg_source: assert property (
    $past(resetn_i, 3) && $past(ce_i) |-> bg_video_o == $past(vid))
    else $error("background source wrong");
endmodule

/* File: verification/osdma_host.sv */
`timescale 1ns/1ps
module osdma_host
(
  // Clock and device status
  input wire logic clk_i,
  input wire logic busy_i,
  input wire logic [7:0] rdata_i,
  // Register port
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] code_o,
  output logic [7:0] wdata_o,
  output logic cs_rise_o
);
  import osdma_pkg::*;
  initial
  begin
    {wr_o, rd_o, cs_rise_o} = 3'h0;
    code_o = 8'h00;
    wdata_o = 8'h00;
  end
  // Address writes wait for an idle memory unless rude is set
  task automatic wr(input logic [7:0] c, d, input bit rude);
    int n;
    for (n = 0; n < 3000 && !rude && busy_i !== 1'b0
         && (c == OSDMA_REG_AH || c == OSDMA_REG_AL); n++)
      @(negedge clk_i);
    @(negedge clk_i);
    {wr_o, code_o, wdata_o} = {1'b1, c, d};
    @(negedge clk_i);
    {wr_o, code_o, wdata_o} = {1'b0, ~c, ~d};
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] q);
    @(negedge clk_i);
    {rd_o, code_o} = {1'b1, c};
    @(negedge clk_i);
    {rd_o, code_o} = {1'b0, ~c};
    @(negedge clk_i);
    q = rdata_i;
  endtask
  task automatic cs();
    @(negedge clk_i);
    cs_rise_o = 1'b1;
    @(negedge clk_i);
    cs_rise_o = 1'b0;
  endtask
endmodule

/* File: verification/osd_display_memory_access_tb_top.sv */
`timescale 1ns/1ps
module osd_display_memory_access_tb_top;
  import osdma_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr, rd, csr, we, cwe, awe, busy, bgv;
  logic vs = 1'b0, ext = 1'b0, bgm = 1'b0, lbg = 1'b0, ce = 1'b1;
  logic [7:0] code, wd, rdat, q, d, mc, ma;
  logic [2:0] at;
  logic [8:0] a;
  logic [OSDMA_ADDR_W-1:0] madr;
  int n_mismatch = 0, compares = 0, cyc = 0, k;
  initial
    forever #12.5 clk = ~clk;
  osdma_host u_osdma_host (.clk_i(clk), .busy_i(busy), .rdata_i(rdat),
    .wr_o(wr), .rd_o(rd), .code_o(code), .wdata_o(wd), .cs_rise_o(csr));
  osdma_top #(.CLEAR_CYCLES(600)) u_osdma_top (.clk_sys_i(clk),
    .resetn_i(rstn), .ce_i(ce), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_code_i(code), .reg_wdata_i(wd), .cs_rise_i(csr), .vsync_i(vs),
    .ext_sync_i(ext), .bg_mode_i(bgm), .local_background_select_i(lbg),
    .reg_rdata_o(rdat), .mem_we_o(we), .mem_addr_o(madr), .mem_char_o(mc),
    .mem_attr_o(ma), .mem_char_we_o(cwe), .mem_attr_we_o(awe),
    .clear_busy_o(busy), .bg_video_o(bgv));
  task automatic summarize();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic mw(input logic [8:0] ea, input logic [1:0] en,
                    input logic [7:0] ec, ey);
    int i;
    for (i = 0; i < 4 && we !== 1'b1; i++)
      @(negedge clk);
    chk("mem_we", 1'b1, we);
    chk("mem_addr", ea, madr);
    chk("char_we", en[0], cwe);
    chk("attr_we", en[1], awe);
    if (en[0])
      chk("mem_char", ec, mc);
    if (en[1])
      chk("mem_attr", ey, ma);
  endtask
  // Counts sweep writes until the clear finishes
  task automatic clr();
    int n, i;
    n = 0;
    for (i = 0; i < 4 && busy !== 1'b1; i++)
      @(negedge clk);
    for (i = 0; i < 3000 && busy !== 1'b0; i++)
    begin
      @(negedge clk);
      n += int'(we === 1'b1);
    end
    chk("sweep_writes", 9'(OSDMA_DEPTH), n[8:0]);
    chk("busy", 1'b0, busy);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  initial
  begin
    void'($urandom(97));
    repeat (10) @(negedge clk);
    chk("busy_in_reset", 1'b1, busy);
    rstn = 1'b1;
    clr();
    u_osdma_host.rd(8'h85, q);
    chk("addr_high", 8'h00, q);
    u_osdma_host.rd(8'h86, q);
    chk("addr_low", 8'h00, q);
    $display("test reset_clear done");
    for (k = 0; k < 4; k++)
    begin
      a = 9'($urandom_range(0, 479));
      u_osdma_host.wr(OSDMA_REG_AH, {7'h00, a[8]}, 1'b0);
      u_osdma_host.wr(OSDMA_REG_AL, a[7:0], 1'b0);
      u_osdma_host.rd(8'h85, q);
      chk("addr_high", {7'h00, a[8]}, q);
      u_osdma_host.rd(8'h86, q);
      chk("addr_low", a[7:0], q);
    end
    $display("test address_regs done");
    a = 9'($urandom_range(0, 470));
    at = 3'($urandom_range(0, 7));
    u_osdma_host.wr(OSDMA_REG_AH, {7'h00, a[8]}, 1'b0);
    u_osdma_host.wr(OSDMA_REG_AL, a[7:0], 1'b0);
    u_osdma_host.wr(OSDMA_REG_CTL, {2'b00, at, 3'b001}, 1'b0);
    for (k = 0; k < 4; k++)
    begin
      d = 8'($urandom_range(0, 254));
      u_osdma_host.wr(OSDMA_REG_DIN, d, 1'b0);
      mw(a + 9'(k), 2'b11, d, {at, 5'h00});
    end
    u_osdma_host.wr(OSDMA_REG_DIN, OSDMA_ESCAPE, 1'b0);
    repeat (3)
    begin
      @(negedge clk);
      chk("mem_we", 1'b0, we);
    end
    u_osdma_host.rd(8'h80, q);
    chk("auto_bit", 1'b0, q[OSDMA_CTL_AUTO]);
    for (k = 0; k < 2; k++)
    begin
      a = 9'($urandom_range(0, 479));
      d = 8'($urandom_range(0, 254));
      u_osdma_host.wr(OSDMA_REG_AH, {6'h00, k[0], a[8]}, 1'b0);
      u_osdma_host.wr(OSDMA_REG_AL, a[7:0], 1'b0);
      u_osdma_host.wr(OSDMA_REG_CTL, 8'h41, 1'b0);
      u_osdma_host.wr(OSDMA_REG_DIN, d, 1'b0);
      mw(a, k[0] ? 2'b10 : 2'b01, d, d);
      u_osdma_host.wr(OSDMA_REG_DIN, OSDMA_ESCAPE, 1'b0);
    end
    a = 9'($urandom_range(0, 479));
    u_osdma_host.wr(OSDMA_REG_AH, {7'h00, a[8]}, 1'b0);
    u_osdma_host.wr(OSDMA_REG_AL, a[7:0], 1'b0);
    u_osdma_host.wr(OSDMA_REG_CTL, {2'b00, at, 3'b000}, 1'b0);
    u_osdma_host.wr(OSDMA_REG_DIN, OSDMA_ESCAPE, 1'b0);
    mw(a, 2'b11, OSDMA_ESCAPE, {at, 5'h00});
    $display("test auto_increment done");
    u_osdma_host.wr(OSDMA_REG_AH, 8'h01, 1'b0);
    u_osdma_host.wr(OSDMA_REG_CTL, 8'h05, 1'b0);
    clr();
    u_osdma_host.rd(8'h80, q);
    chk("control", 8'h00, q);
    u_osdma_host.wr(OSDMA_REG_CTL, 8'h06, 1'b0);
    repeat (20) @(negedge clk);
    u_osdma_host.rd(8'h80, q);
    chk("control", 8'h06, q);
    u_osdma_host.wr(OSDMA_REG_AH, 8'h00, 1'b1);
    vs = 1'b1;
    clr();
    vs = 1'b0;
    u_osdma_host.rd(8'h85, q);
    chk("addr_high", 8'h01, q);
    u_osdma_host.wr(OSDMA_REG_VMODE0, 8'h02, 1'b0);
    u_osdma_host.cs();
    @(negedge clk);
    chk("busy", 1'b1, busy);
    clr();
    $display("test clear done");
    for (k = 0; k < 8; k++)
    begin
      {ext, bgm, lbg} = k[2:0];
      repeat (2) @(negedge clk);
      chk("bg_video", k == 4, bgv);
    end
    ce = 1'b0;
    {ext, bgm, lbg} = 3'h4;
    repeat (2) @(negedge clk);
    chk("bg_frozen", 1'b0, bgv);
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk("bg_video", 1'b1, bgv);
    $display("test background done");
    summarize();
  end
endmodule
bind osdma_top osdma_top_props #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_props (.*);
